// ---- core/bstp_pkg.sv ----
// shared constants and types for the boundary scan test port
package bstp_pkg;
  // instruction register
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] IR_PROGRAM = 4'h3;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;  // low bits 01 as usual
  localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;
  // data registers
  localparam int ID_W = 32;
  localparam int PROG_W = 32;
  localparam int CELL_BITS = 3;  // capture stages per cell
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int FIFO_DEPTH = 16;
  // pin index inside the four-pin test port group
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;
  localparam logic [3:0] PIN_RESET_VAL = 4'h0;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } bstp_state_t;

  // synchronised test port inputs
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstp_link_t;
endpackage

// ---- core/bstp_top.sv ----
// boundary scan test port: tap controller, boundary chain and programming fifo
// How it works
// - the tap controller is reset by the power-up reset and by disabling the port, there is no separate test reset pin.
// - sample/preload, extest, bypass and idcode instructions are decoded from the instruction register.
// - every dedicated input and i/o pin owns a boundary cell for observe and control.
// - cells come in two kinds, pin cells and macrocell cells, placed by one generate loop.
// - each cell has three capture/shift stages and two update stages (output value and enable).
// - all cells form one serial chain from tdi to tdo through their capture stages.
// - capture stages sample live signals, shift chain data and load the update stages.
// - capture, shift and update strobes all come from the tap state machine inside the block.
// - a programming instruction takes 32-bit words over the four port pins into a fifo.
// - the chain covers up to 96 i/o pins plus four dedicated inputs, set by parameter.
// - scan follows the usual 1149.1 behaviour so any tester reading the description model works.
////////////////////////////////////////////////////////////////////////////////
// simple synchronous fifo with valid/ready on both sides
module bstp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  // storage has no reset, only the pointers need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // pointers carry one wrap bit so full and empty differ
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module bstp_top
  import bstp_pkg::*;
#(
  parameter int N_PIN = 100,  // 96 i/o plus four dedicated inputs
  parameter int N_MC = 128,
  parameter logic [ID_W-1:0] IDCODE_VAL = 32'h0000_0001  // arbitrary value
) (
  // clock and power-up reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration: test port on, else pins are user i/o
  input wire logic port_enable,
  // the four test port pins
  input wire logic [3:0] port_pin_in,
  output logic [3:0] port_pin_out,
  output logic [3:0] port_pin_oe,
  // user side of the four port pins when the port is disabled
  input wire logic [3:0] user_pin_out,
  input wire logic [3:0] user_pin_oe,
  output logic [3:0] user_pin_in,
  // boundary cells: core side and pad/net side
  input wire logic [N_PIN+N_MC-1:0] sys_out,
  input wire logic [N_PIN+N_MC-1:0] sys_oe,
  output logic [N_PIN+N_MC-1:0] core_in,
  input wire logic [N_PIN+N_MC-1:0] pad_in,
  output logic [N_PIN+N_MC-1:0] pad_out,
  output logic [N_PIN+N_MC-1:0] pad_oe,
  // programming words toward the array programmer
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [PROG_W-1:0] prog_data
);
  localparam int N = N_PIN + N_MC;
  localparam int BSR_W = N * CELL_BITS;
  // next tap state for a given tms
  function automatic bstp_state_t tap_next(input bstp_state_t s, input logic tms);
    case (s)
      TEST_LOGIC_RESET: tap_next = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: tap_next = tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_next = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_next = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: tap_next = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_next = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_next = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: tap_next = tms ? SELECT_DR : RUN_TEST_IDLE;
      default: tap_next = TEST_LOGIC_RESET;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for port pins and pads
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [N-1:0] pad_meta;
  logic [N-1:0] pad_sync;
  logic tck_last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= PIN_RESET_VAL;
      pin_sync <= PIN_RESET_VAL;
      pad_meta <= '0;
      pad_sync <= '0;
      tck_last <= 1'b0;
    end else begin
      pin_meta <= port_pin_in;
      pin_sync <= pin_meta;
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
      tck_last <= pin_sync[PIN_TCK];
    end
  end
  bstp_link_t link;
  assign link = '{tck: pin_sync[PIN_TCK], tms: pin_sync[PIN_TMS], tdi: pin_sync[PIN_TDI]};
  // a disabled port sees no tck edges at all
  wire tck_rise = port_enable && link.tck && !tck_last;
  wire tck_fall = port_enable && !link.tck && tck_last;
  ////////////////////////////////////////////////////////////////////////////
  // tap state and instruction register
  bstp_state_t state;
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] ir;
  wire bstp_state_t next_state = tap_next(state, link.tms);
  // decoded strobes from the state machine, register selects from the instruction register
  wire cap_dr = tck_rise && state == CAPTURE_DR;
  wire sh_dr = tck_rise && state == SHIFT_DR;
  wire upd_dr = tck_rise && state == UPDATE_DR;
  wire sel_bsr = ir == IR_EXTEST || ir == IR_SAMPLE;
  wire sel_id = ir == IR_IDCODE;
  wire sel_prog = ir == IR_PROGRAM;
  wire is_extest = ir == IR_EXTEST;
  // disabling the port or power-up puts the tap back in reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TEST_LOGIC_RESET;
    end else if (!port_enable) begin
      state <= TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end
  // instruction capture, shift and update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift <= '0;
      ir <= IR_RESET_VAL;
    end else if (tck_rise) begin
      if (state == TEST_LOGIC_RESET) ir <= IR_RESET_VAL;
      if (state == CAPTURE_IR) ir_shift <= IR_CAPTURE_VAL;
      if (state == SHIFT_IR) ir_shift <= {link.tdi, ir_shift[IR_W-1:1]};
      if (state == UPDATE_IR) ir <= ir_shift;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // boundary chain: three capture stages and two update stages per cell
  logic [BSR_W-1:0] bsr;
  logic [N-1:0] upd_out;
  logic [N-1:0] upd_oe;
  logic [BSR_W-1:0] live;
  // pin cells first, macrocell cells after; same stage layout for both kinds
  for (genvar i = 0; i < N; i++) begin : g_cell
    assign live[i*CELL_BITS+CELL_IN] = pad_sync[i];
    assign live[i*CELL_BITS+CELL_OUT] = sys_out[i];
    assign live[i*CELL_BITS+CELL_OE] = sys_oe[i];
  end
  // capture, shift tdi toward bit 0, load update stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr <= '0;
      upd_out <= '0;
      upd_oe <= '0;
    end else if (sel_bsr) begin
      if (cap_dr) bsr <= live;
      if (sh_dr) bsr <= {link.tdi, bsr[BSR_W-1:1]};
      for (int i = 0; i < N; i++) begin
        if (upd_dr) upd_out[i] <= bsr[i*CELL_BITS+CELL_OUT];
        if (upd_dr) upd_oe[i] <= bsr[i*CELL_BITS+CELL_OE];
      end
    end
  end
  // extest drives pads from update stages, otherwise the core is transparent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe <= '0;
      core_in <= '0;
    end else begin
      pad_out <= is_extest ? upd_out : sys_out;
      pad_oe <= is_extest ? upd_oe : sys_oe;
      core_in <= pad_sync;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bypass, idcode and programming data registers
  logic bypass;
  logic [ID_W-1:0] id_shift;
  logic [PROG_W-1:0] prog_shift;
  logic word_dropped;
  logic fifo_in_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass <= 1'b0;
      id_shift <= '0;
      prog_shift <= '0;
    end else begin
      if (cap_dr) bypass <= 1'b0;
      if (sh_dr) bypass <= link.tdi;
      if (cap_dr && sel_id) id_shift <= IDCODE_VAL | 32'h0000_0001;
      if (sh_dr && sel_id) id_shift <= {link.tdi, id_shift[ID_W-1:1]};
      // capture lets the programmer poll space and a lost word
      if (cap_dr && sel_prog) prog_shift <= {{(PROG_W-2){1'b0}}, word_dropped, fifo_in_ready};
      if (sh_dr && sel_prog) prog_shift <= {link.tdi, prog_shift[PROG_W-1:1]};
    end
  end
  // a word updated into a full fifo is not stored; the flag tells the programmer
  wire push_word = upd_dr && sel_prog;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_dropped <= 1'b0;
    end else if (push_word && !fifo_in_ready) begin
      word_dropped <= 1'b1;  // set wins over the clear below
    end else if (cap_dr && sel_prog) begin
      word_dropped <= 1'b0;
    end
  end
  bstp_fifo #(.WIDTH(PROG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_word),
    .in_ready(fifo_in_ready),
    .in_data(prog_shift),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // tdo source selection and falling-edge output
  wire in_shift_ir = state == SHIFT_IR;
  wire in_shift_dr = state == SHIFT_DR;
  wire dr_bit = sel_bsr ? bsr[0] : sel_id ? id_shift[0] : sel_prog ? prog_shift[0] : bypass;
  wire tdo_bit = in_shift_ir ? ir_shift[0] : dr_bit;
  logic tdo_q;
  logic tdo_en;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_en <= 1'b0;
    end else if (!port_enable) begin
      tdo_en <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tdo_bit;
      tdo_en <= in_shift_ir || in_shift_dr;
    end
  end
  // port pins: test port or user i/o, chosen by the option
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pin_out <= PIN_RESET_VAL;
      port_pin_oe <= PIN_RESET_VAL;
      user_pin_in <= PIN_RESET_VAL;
    end else if (port_enable) begin
      port_pin_out <= {tdo_q, 3'h0};
      port_pin_oe <= {tdo_en, 3'h0};
      user_pin_in <= PIN_RESET_VAL;
    end else begin
      port_pin_out <= user_pin_out;
      port_pin_oe <= user_pin_oe;
      user_pin_in <= pin_sync;
    end
  end
endmodule

// ---- dv/bstp_checker.sv ----
// concurrent checks on the test port top, bound to every instance
module bstp_checker
  import bstp_pkg::*;
#(
  parameter int N_PIN = 100,
  parameter int N_MC = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // test port and user pins
  input wire logic port_enable,
  input wire logic [3:0] port_pin_in,
  input wire logic [3:0] port_pin_out,
  input wire logic [3:0] port_pin_oe,
  input wire logic [3:0] user_pin_out,
  input wire logic [3:0] user_pin_oe,
  input wire logic [3:0] user_pin_in,
  // boundary cells, core side and pad side
  input wire logic [N_PIN+N_MC-1:0] core_in,
  input wire logic [N_PIN+N_MC-1:0] pad_in,
  // programming words
  input wire logic prog_valid,
  input wire logic prog_ready,
  input wire logic [PROG_W-1:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // port off: pins follow the user drive one clock late
  a_user_out_copy:
    assert property ($past(rst_n) && $past(!port_enable) |-> port_pin_out == $past(user_pin_out)) else $error("user drive lost");
  a_user_oe_copy:
    assert property ($past(rst_n) && $past(!port_enable) |-> port_pin_oe == $past(user_pin_oe)) else $error("user enable lost");
  // port on: user side sees nothing, only tdo may drive
  a_user_in_quiet:
    assert property ($past(rst_n) && $past(port_enable) |-> user_pin_in == 4'h0) else $error("user input leaks");
  a_port_in_only:
    assert property ($past(rst_n) && $past(port_enable) |-> port_pin_oe[2:0] == 3'h0 && port_pin_out[2:0] == 3'h0)
      else $error("input pin driven");
  // tdo moves only a few clocks after a tck fall, never while tck stays low
  a_tdo_after_fall:
    assert property (port_enable [*4] ##0 $changed(port_pin_out[3]) |-> !$past(port_pin_in[0], 3)) else $error("tdo moved off fall");
  a_tdo_quiet:
    assert property ((port_enable && !port_pin_in[0]) [*6] |-> $stable(port_pin_out[3]) && $stable(port_pin_oe[3]))
      else $error("tdo unstable");
  // scan never overrides the core side: pads arrive after the sync stages
  a_core_in_delay:
    assert property (rst_n [*4] |-> core_in == $past(pad_in, 3)) else $error("core input latency");
  // a stalled word stays offered unchanged
  a_prog_held:
    assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data)) else $error("word dropped in stall");
endmodule

bind bstp_top bstp_checker #(.N_PIN(N_PIN), .N_MC(N_MC)) i_checker (
  .clk(clk), .rst_n(rst_n), .port_enable(port_enable), .port_pin_in(port_pin_in),
  .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .user_pin_out(user_pin_out),
  .user_pin_oe(user_pin_oe), .user_pin_in(user_pin_in), .core_in(core_in), .pad_in(pad_in),
  .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data)
);

// ---- dv/bstp_tester.sv ----
// external scan tester model driving tck, tms and tdi and reading tdo on the four test port pins
module bstp_tester (
  // bench clock
  input wire logic clk,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // tck idles low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one 80 ns tck period, 50 low and 30 high; tdo is read late so it has settled
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (5) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (3) @(negedge clk);
    tck = 1'b0;
  endtask

  // five ones reach reset from any state, then park in idle
  task automatic reset_tap();
    logic q;
    @(negedge clk);
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // one ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    @(negedge clk);
    dout = 32'h0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the boundary scan test port
module testbench
  import bstp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 4;
  localparam int N = NP + 2;
  localparam logic [ID_W-1:0] ID = 32'h5a3c_9e60; // arbitrary value
  localparam logic [31:0] BSR_DIN = 32'h0002_b5c6; // preload pattern for the chain
  typedef struct packed {logic [3:0] ir; logic [31:0] din; logic [31:0] dout;} bstp_row_t;
  // bypass shifts by one with a zero up front; unused codes act the same
  bstp_row_t rows [3] = '{'{IR_IDCODE, 32'hffff_0000, ID | 32'h1},
    '{IR_BYPASS, 32'h8000_0003, 32'h0000_0006}, '{4'h7, 32'h1234_5678, 32'h2468_acf0}};
  logic clk, rst_n, port_enable, prog_ready, prog_valid, tck, tms, tdi, tdo_pin;
  logic tdo_last = 1'b0;
  logic [3:0] pin_in, pin_out, pin_oe, user_out, user_oe, user_in;
  logic [N-1:0] sys_out, sys_oe, core_in, pad_in, pad_out, pad_oe;
  logic [31:0] got, want, prog_data;
  int n_fail, compares;

  ////////////////////////////////////////////////////////////////////////////////
  // undriven tdo floats: show the inverse of its last level, not a stale copy
  always @(posedge clk) if (pin_oe[3]) tdo_last <= pin_out[3];
  assign tdo_pin = pin_oe[3] ? pin_out[3] : !tdo_last;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {tdo_pin, tdi, tms, tck});

  bstp_top #(.N_PIN(NP), .N_MC(2), .IDCODE_VAL(ID)) i_dut (.clk(clk), .rst_n(rst_n), .port_enable(port_enable),
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe), .user_pin_out(user_out),
    .user_pin_oe(user_oe), .user_pin_in(user_in), .sys_out(sys_out), .sys_oe(sys_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_data(prog_data));
  bstp_tester i_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a full run needs about 77 us; hang guard well above
  initial begin
    #600us;
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    port_enable = 1'b1;
    prog_ready = 1'b0;
    user_out = 4'h2;
    user_oe = 4'h3;
    sys_out = 6'h2d;
    sys_oe = 6'h33;
    pad_in = 6'h1a;
    n_fail = 0;
    compares = 0;
    repeat (3) @(negedge clk);
    check({pad_out, pad_oe, pin_oe, prog_valid}, 32'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check(core_in, pad_in);
    i_tester.reset_tap();
    i_tester.scan(1'b0, 32, 32'h0, got);
    check(got, ID | 32'h1);
    foreach (rows[i]) begin
      i_tester.scan(1'b1, IR_W, {28'h0, rows[i].ir}, got);
      check(got, {28'h0, IR_CAPTURE_VAL});
      i_tester.scan(1'b0, 32, rows[i].din, got);
      check(got, rows[i].dout);
    end
    // sample captures pad, out, oe per cell and preloads the update stages
    want = 32'h0;
    for (int i = 0; i < N; i++) want[3*i +: 3] = {sys_oe[i], sys_out[i], pad_in[i]};
    i_tester.scan(1'b1, IR_W, {28'h0, IR_SAMPLE}, got);
    i_tester.scan(1'b0, 3 * N, BSR_DIN, got);
    check(got, want);
    check({pad_out, pad_oe}, {sys_out, sys_oe});
    i_tester.scan(1'b1, IR_W, {28'h0, IR_EXTEST}, got);
    // pads switch source one clock after the instruction lands, which is after the scan returns
    repeat (2) @(negedge clk);
    for (int i = 0; i < N; i++) want[i] = BSR_DIN[3*i+1];
    for (int i = 0; i < N; i++) want[N+i] = BSR_DIN[3*i+2];
    check({pad_oe, pad_out}, want[2*N-1:0]);
    i_tester.scan(1'b1, IR_W, {28'h0, IR_BYPASS}, got);
    repeat (2) @(negedge clk);
    check({pad_out, pad_oe}, {sys_out, sys_oe});
    // fill the fifo with the drain stalled until a word is refused
    i_tester.scan(1'b1, IR_W, {28'h0, IR_PROGRAM}, got);
    for (int k = 0; k < 18; k++) begin
      i_tester.scan(1'b0, 32, 32'hc0de_0000 + k, got);
      check(got, k < 16 ? 32'h1 : (k == 16 ? 32'h0 : 32'h2));
    end
    for (int k = 0; k < 16; k++) begin
      check(prog_valid, 1'b1);
      check(prog_data, 32'hc0de_0000 + k);
      prog_ready = 1'b1;
      @(negedge clk);
      prog_ready = 1'b0;
      @(negedge clk);
    end
    check(prog_valid, 1'b0);
    // port off: pins belong to the user
    port_enable = 1'b0;
    pad_in = 6'h25;
    repeat (5) @(negedge clk);
    check({pin_out, pin_oe}, {user_out, user_oe});
    check(core_in, pad_in);
    check(user_in[2:0], {tdi, user_out[1:0]});
    port_enable = 1'b1;
    // second reset mid-run brings idcode back
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    i_tester.reset_tap();
    i_tester.scan(1'b0, 32, 32'h0, got);
    check(got, ID | 32'h1);
    print_verdict();
  end
endmodule
